// File: inc/qct_defs.vh
`ifndef QCT_DEFS_VH
`define QCT_DEFS_VH
// control word field positions
`define QCT_CW_IRQ_EN 7
`define QCT_CW_MODE 6
`define QCT_CW_PRESC 5
`define QCT_CW_EDGE 4
`define QCT_CW_TRIG 3
`define QCT_CW_TC_NEXT 2
`define QCT_CW_SWRST 1
`define QCT_CW_IS_CTRL 0
// reset values
`define QCT_CTRL_RST 8'h00
`define QCT_VEC_RST 5'h00
// prescaler divide factors
`define QCT_PRESC_SMALL 9'h010
`define QCT_PRESC_LARGE 9'h100
`define QCT_PRESC_SMALL_M1 8'h0F
`define QCT_PRESC_LARGE_M1 8'hFF
// first opcode byte of return from interrupt, then its second byte
`define QCT_RETURN_FROM_IRQ_INSTR_B1 8'hED
`define QCT_RETURN_FROM_IRQ_INSTR_B2 8'h4D
`endif

// File: core/qct_vec_store.v
`timescale 1ns/1ps
// per-channel time constant store, read data registered
module qct_vec_store
#(
   parameter NCH = 4,
   parameter AW = 2,
   parameter DW = 8
)
(
   input wire clk,
   input wire reset,
   input wire wr_en,
   input wire [AW-1:0] wr_addr,
   input wire [DW-1:0] wr_data,
   input wire [AW-1:0] rd_addr,
   output reg [DW-1:0] rd_data
);
   // storage array, not reset: host must program before use
   reg [DW-1:0] mem [0:NCH-1];

   // write port
   always @(posedge clk)
   begin
      if (wr_en)
         mem[wr_addr] <= wr_data;
   end

   // registered read port
   always @(posedge clk or posedge reset)
   begin
      if (reset)
         rd_data <= {DW{1'b0}};
      else
         rd_data <= mem[rd_addr];
   end
endmodule

// File: core/qct_top.v
`timescale 1ns/1ps
`include "qct_defs.vh"
module qct_top
#(
   parameter NCH = 4
)
(
   input wire clk,
   input wire reset,
   input wire chip_enable_n,
   input wire io_request_n,
   input wire read_n,
   input wire opcode_fetch_cycle_n,
   input wire chan_select_lo,
   input wire chan_select_hi,
   input wire [7:0] data_in,
   output reg [7:0] data_out,
   output reg data_oe,
   input wire chain_priority_in,
   output reg chain_priority_out,
   output reg irq_out_n,
   output reg irq_oe,
   input wire [NCH-1:0] ext_count_trigger,
   output reg [NCH-2:0] zero_count_pulse
);
   // decoded bus events
   wire [1:0] sel; // channel number
   wire cyc; // any io cycle on us
   wire ack; // interrupt acknowledge
   wire fetch; // opcode fetch, no io
   reg cyc_q; // io cycle seen last clock
   reg ack_q; // ack seen last clock
   reg fetch_q; // fetch seen last clock
   wire wr_stb; // one pulse per write
   wire rd_act; // read in progress
   wire ack_stb; // one pulse per ack
   wire fetch_end; // fetch just finished
   reg [7:0] fetch_byte_q; // opcode latched in fetch
   reg ed_seen_q; // previous fetch was first byte

   assign sel = {chan_select_hi, chan_select_lo};
   assign cyc = !chip_enable_n && !io_request_n && opcode_fetch_cycle_n;
   assign ack = !io_request_n && !opcode_fetch_cycle_n;
   assign fetch = !opcode_fetch_cycle_n && io_request_n;
   assign wr_stb = cyc && !cyc_q && read_n;
   assign rd_act = cyc && !read_n;
   assign ack_stb = ack && !ack_q;
   assign fetch_end = fetch_q && !fetch;

   // per-channel state
   reg [7:0] ctrl_q [0:NCH-1]; // channel_control
   reg [NCH-1:0] tc_next_q; // constant word expected next
   reg [NCH-1:0] run_q; // channel counting
   reg [NCH-1:0] armed_q; // timer waits for trigger
   reg [NCH-1:0] pend_tc_q; // new constant waits for zero
   reg [NCH-1:0] load_q; // reload counter next clock
   reg [7:0] cnt_q [0:NCH-1]; // remaining_count
   reg [7:0] tc_q [0:NCH-1]; // time_constant
   reg [7:0] pre_q [0:NCH-1]; // prescaler
   reg [NCH-1:0] sync1_q; // trigger sync stage one
   reg [NCH-1:0] sync2_q; // trigger sync stage two
   reg [NCH-1:0] sync3_q; // delayed for edge detect
   reg [NCH-1:0] zc_q; // zero reached this clock
   reg [NCH-1:0] ip_q; // interrupt pending
   reg [NCH-1:0] ius_q; // interrupt under service
   reg [4:0] vec_q; // shared vector high bits
   wire [NCH-1:0] chain_en; // priority into each slot
   wire [NCH-1:0] dec_tick; // decrement this clock
   wire [NCH-1:0] trig_act; // synced active edge
   wire [NCH-1:0] win; // acknowledged channel

   // constant kept also in a small store, never read back
   qct_vec_store #(.NCH(NCH), .AW(2), .DW(8)) u_tc
   (
      .clk(clk),
      .reset(reset),
      .wr_en(wr_stb && tc_next_q[sel]),
      .wr_addr(sel),
      .wr_data(data_in),
      .rd_addr(sel),
      .rd_data() // read port spare, constant also in tc_q
   );

   // bus edge trackers, opcode capture for return decode
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         cyc_q <= 1'b0;
         ack_q <= 1'b0;
         fetch_q <= 1'b0;
         fetch_byte_q <= 8'h00;
         ed_seen_q <= 1'b0;
      end
      else
      begin
         cyc_q <= cyc;
         ack_q <= ack;
         fetch_q <= fetch;
         if (fetch)
            fetch_byte_q <= data_in;
         // flag lasts through the following fetch only
         if (fetch_end)
            ed_seen_q <= (fetch_byte_q == `QCT_RETURN_FROM_IRQ_INSTR_B1);
      end
   end

   // daisy chain inside: slot n sees priority only if all above idle
   assign chain_en[0] = chain_priority_in;
   genvar g;
   generate
      for (g = 0; g < NCH; g = g + 1)
      begin : gch
         if (g > 0)
         begin : gce
            // higher slot blocks lower while serviced/pending
            assign chain_en[g] = chain_en[g-1] && !ius_q[g-1] &&
               !(ip_q[g-1] && !ed_seen_q);
         end
         // edge select flips polarity of synced input
         assign trig_act[g] = (sync2_q[g] ^ sync3_q[g]) &&
            (sync2_q[g] == ctrl_q[g][`QCT_CW_EDGE]);
         assign dec_tick[g] = run_q[g] &&
            (ctrl_q[g][`QCT_CW_MODE] ?
               trig_act[g] :
               (pre_q[g] == 8'h00));
         assign win[g] = chain_en[g] && ip_q[g] && !ius_q[g];

         // channel engine
         always @(posedge clk or posedge reset)
         begin
            if (reset)
            begin
               ctrl_q[g] <= `QCT_CTRL_RST;
               tc_next_q[g] <= 1'b0;
               run_q[g] <= 1'b0;
               armed_q[g] <= 1'b0;
               pend_tc_q[g] <= 1'b0;
               load_q[g] <= 1'b0;
               cnt_q[g] <= 8'h00;
               tc_q[g] <= 8'h00;
               pre_q[g] <= 8'h00;
               sync3_q[g] <= 1'b0;
               zc_q[g] <= 1'b0;
               ip_q[g] <= 1'b0;
               ius_q[g] <= 1'b0;
            end
            else
            begin
               sync3_q[g] <= sync2_q[g];
               zc_q[g] <= 1'b0;
               load_q[g] <= 1'b0;
               // prescaler free runs only while timing
               if (run_q[g] && !ctrl_q[g][`QCT_CW_MODE])
               begin
                  if (pre_q[g] == 8'h00)
                     pre_q[g] <= ctrl_q[g][`QCT_CW_PRESC] ?
                        `QCT_PRESC_LARGE_M1 :
                        `QCT_PRESC_SMALL_M1;
                  else
                     pre_q[g] <= pre_q[g] - 8'h01;
               end
               // armed timer starts on active edge
               if (armed_q[g] && trig_act[g])
               begin
                  armed_q[g] <= 1'b0;
                  run_q[g] <= 1'b1;
               end
               // acknowledge first, so a fresh zero this clock re-pends
               if (ack_stb && win[g])
               begin
                  ius_q[g] <= 1'b1;
                  ip_q[g] <= 1'b0;
               end
               // down count; zero is 256 by wrapping
               if (load_q[g])
                  cnt_q[g] <= tc_q[g];
               else if (dec_tick[g])
               begin
                  cnt_q[g] <= cnt_q[g] - 8'h01;
                  if (cnt_q[g] == 8'h01)
                  begin
                     zc_q[g] <= 1'b1;
                     load_q[g] <= 1'b1;
                     pend_tc_q[g] <= 1'b0;
                     if (ctrl_q[g][`QCT_CW_IRQ_EN])
                        ip_q[g] <= 1'b1;
                  end
               end
               // host writes to this channel
               if (wr_stb && sel == g)
               begin
                  if (tc_next_q[g])
                  begin
                     tc_next_q[g] <= 1'b0;
                     tc_q[g] <= data_in;
                     if (!run_q[g] && !armed_q[g])
                     begin
                        // first constant or after soft reset
                        load_q[g] <= 1'b1;
                        pre_q[g] <= 8'h00;
                        if (ctrl_q[g][`QCT_CW_MODE] ||
                           !ctrl_q[g][`QCT_CW_TRIG])
                           run_q[g] <= 1'b1;
                        else
                           armed_q[g] <= 1'b1;
                     end
                     else
                        pend_tc_q[g] <= 1'b1;
                  end
                  else if (data_in[`QCT_CW_IS_CTRL])
                  begin
                     ctrl_q[g] <= data_in;
                     tc_next_q[g] <= data_in[`QCT_CW_TC_NEXT];
                     if (data_in[`QCT_CW_SWRST])
                     begin
                        run_q[g] <= 1'b0;
                        armed_q[g] <= 1'b0;
                     end
                     else if (data_in[`QCT_CW_EDGE] !=
                        ctrl_q[g][`QCT_CW_EDGE])
                     begin
                        // slope change counts as an edge
                        if (armed_q[g])
                        begin
                           armed_q[g] <= 1'b0;
                           run_q[g] <= 1'b1;
                        end
                        else if (run_q[g] && ctrl_q[g][`QCT_CW_MODE])
                        begin
                           cnt_q[g] <= cnt_q[g] - 8'h01;
                           if (cnt_q[g] == 8'h01)
                           begin
                              zc_q[g] <= 1'b1;
                              load_q[g] <= 1'b1;
                           end
                        end
                     end
                     if (!data_in[`QCT_CW_IRQ_EN])
                        ip_q[g] <= 1'b0;
                  end
               end
               // return completes: highest serviced slot clears
               if (fetch_end && ed_seen_q &&
                  fetch_byte_q == `QCT_RETURN_FROM_IRQ_INSTR_B2 &&
                  chain_en[g] && ius_q[g])
                  ius_q[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // trigger synchroniser, two stages
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         sync1_q <= {NCH{1'b0}};
         sync2_q <= {NCH{1'b0}};
      end
      else
      begin
         sync1_q <= ext_count_trigger;
         sync2_q <= sync1_q;
      end
   end

   // vector register: bit0 clear on channel 0 port
   always @(posedge clk or posedge reset)
   begin
      if (reset)
         vec_q <= `QCT_VEC_RST;
      else if (wr_stb && sel == 2'b00 && !tc_next_q[0] &&
         !data_in[`QCT_CW_IS_CTRL])
         vec_q <= data_in[7:3];
   end

   // winning channel number by fixed priority
   reg [1:0] win_num; // encoded winner
   reg win_any; // some channel won
   integer i;
   always @*
   begin
      win_num = 2'b00;
      win_any = 1'b0;
      for (i = NCH - 1; i >= 0; i = i - 1)
      begin
         if (win[i])
         begin
            win_num = i[1:0];
            win_any = 1'b1;
         end
      end
   end

   // output registers: data bus, irq, zero pulses
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         data_out <= 8'h00;
         data_oe <= 1'b0;
         irq_out_n <= 1'b1;
         irq_oe <= 1'b0;
         zero_count_pulse <= {(NCH-1){1'b0}};
      end
      else
      begin
         if (ack_stb && win_any)
         begin
            data_out <= {vec_q, win_num, 1'b0};
            data_oe <= 1'b1;
         end
         else if (ack && ack_q && data_oe)
            data_oe <= 1'b1; // vector stands for whole acknowledge
         else if (rd_act)
         begin
            data_out <= cnt_q[sel];
            data_oe <= 1'b1;
         end
         else
            data_oe <= 1'b0;
         // open drain request: drive low when any pending
         irq_out_n <= !(|ip_q);
         irq_oe <= |ip_q;
         zero_count_pulse <= zc_q[NCH-2:0];
      end
   end

   // blocked by service or unreleased pending
   // no async reset: state is cleared, so chain out follows chain in
   always @(posedge clk)
   begin
      chain_priority_out <= chain_en[NCH-1] && !ius_q[NCH-1] &&
         !(ip_q[NCH-1] && !ed_seen_q);
   end
endmodule

// File: tb/qct_chk_assertions.sv
`timescale 1ns/1ps
// bus, chain and pulse relations seen at the top ports
module qct_chk
#(
   parameter NCH = 4
)
(
   input wire clk,
   input wire reset,
   input wire chip_enable_n,
   input wire io_request_n,
   input wire read_n,
   input wire opcode_fetch_cycle_n,
   input wire [7:0] data_out,
   input wire data_oe,
   input wire chain_priority_in,
   input wire chain_priority_out,
   input wire irq_out_n,
   input wire irq_oe,
   input wire [NCH-2:0] zero_count_pulse
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // acknowledge with a request up and priority held
   sequence ack_s;
      $fell(io_request_n) && !opcode_fetch_cycle_n && !irq_out_n
         && chain_priority_in;
   endsequence
   sequence rd_s;
      $fell(io_request_n) && !chip_enable_n && !read_n
         && opcode_fetch_cycle_n;
   endsequence
   // three quiet fetch slots keep the return-decode lift out
   sequence no_fetch_s;
      opcode_fetch_cycle_n [*3];
   endsequence
   chain_block_a:
   assert property (!chain_priority_in |=> !chain_priority_out)
      else $error("chain out high while chain in low");
   pend_block_a:
   assert property (no_fetch_s ##0 !irq_out_n |-> !chain_priority_out)
      else $error("chain out high with a request pending");
   serv_block_a:
   assert property (ack_s |-> ##2 !chain_priority_out [*4])
      else $error("chain out high while serviced");
   ack_vec_a:
   assert property (ack_s |-> ##[1:2] (data_oe && !data_out[0]))
      else $error("no vector after acknowledge");
   rd_drive_a:
   assert property (rd_s |-> ##[1:2] data_oe)
      else $error("no drive on count read");
   wr_quiet_a:
   assert property ((!io_request_n && read_n && opcode_fetch_cycle_n)
      [*3] |-> !data_oe)
      else $error("bus driven during a write");
   bus_free_a:
   assert property (io_request_n [*3] |-> !data_oe)
      else $error("bus driven with no request");
   zc_short_a:
   assert property (|zero_count_pulse |=>
      !(|(zero_count_pulse & $past(zero_count_pulse))))
      else $error("zero pulse longer than one clock");
   rst_quiet_a:
   assert property (disable iff (1'b0) reset |-> !data_oe && !irq_oe
      && irq_out_n && !(|zero_count_pulse))
      else $error("outputs active in reset");
endmodule
bind qct_top qct_chk #(.NCH(NCH)) chk (.clk, .reset, .chip_enable_n,
   .io_request_n, .read_n, .opcode_fetch_cycle_n, .data_out, .data_oe,
   .chain_priority_in, .chain_priority_out, .irq_out_n, .irq_oe,
   .zero_count_pulse);

// File: tb/qct_host.sv
`timescale 1ns/1ps
// host bus model: one access at a time, io strobes held three edges, fetch two
module qct_host
(
   input wire clk,
   output logic ce_n,
   output logic io_request_n_n,
   output logic rd_n,
   output logic m1_n,
   output logic cs_lo,
   output logic cs_hi,
   output logic [7:0] d
);
   initial {ce_n, io_request_n_n, rd_n, m1_n, cs_lo, cs_hi, d} = 14'h3c00;
   // write, read or acknowledge; request gap of one clock or more
   task cyc(input logic [1:0] ch, input logic rd, input logic ack,
      input logic [7:0] v);
      @(posedge clk);
      #2;
      {cs_hi, cs_lo} = ch;
      d = v;
      rd_n = !rd;
      m1_n = !ack;
      ce_n = ack;
      io_request_n_n = 1'b0;
      repeat (3) @(posedge clk);
      #2;
      {io_request_n_n, rd_n, m1_n, ce_n} = 4'hf;
      d = ~v; // released bus shows no stale value
   endtask
   // opcode fetch slot without an io request
   task fetch(input logic [7:0] op);
      @(posedge clk);
      #2;
      m1_n = 1'b0;
      d = op;
      repeat (2) @(posedge clk);
      #2;
      m1_n = 1'b1;
      d = ~op;
   endtask
endmodule

// File: tb/quad_counter_timer_daisy_irq_test.sv
`timescale 1ns/1ps
// self-checking run: counters, timer, vectored interrupt
module quad_counter_timer_daisy_irq_test;
   logic clk = 1'b0;
   logic reset = 1'b0;
   logic chain_in = 1'b1;
   logic [3:0] trg = 4'h0;
   logic doe_q = 1'b0;
   wire ce_n, io_request_n_n, rd_n, m1_n, cs_lo, cs_hi;
   wire [7:0] din;
   wire [7:0] dout;
   wire doe, chain_out, irq_n, irq_oe;
   wire [2:0] zc;
   int miscompares = 0;
   int n_tests = 0;
   int seed = 32'hb1cc;
   int zc_cnt [3] = '{0, 0, 0};
   logic [7:0] exp_q [$];
   initial forever #12.5 clk = ~clk;
   qct_top #(.NCH(4)) uut
   (
      .clk(clk), .reset(reset), .chip_enable_n(ce_n),
      .io_request_n(io_request_n_n), .read_n(rd_n), .opcode_fetch_cycle_n(m1_n),
      .chan_select_lo(cs_lo), .chan_select_hi(cs_hi), .data_in(din),
      .data_out(dout), .data_oe(doe), .chain_priority_in(chain_in),
      .chain_priority_out(chain_out), .irq_out_n(irq_n),
      .irq_oe(irq_oe), .ext_count_trigger(trg), .zero_count_pulse(zc)
   );
   qct_host host
   (
      .clk(clk), .ce_n(ce_n), .io_request_n_n(io_request_n_n), .rd_n(rd_n),
      .m1_n(m1_n), .cs_lo(cs_lo), .cs_hi(cs_hi), .d(din)
   );
   task conclude;
      $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task check(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         miscompares++;
         $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   // a fresh bus drive is one result: oldest note is compared
   always @(negedge clk)
   begin
      doe_q <= doe;
      if (doe && !doe_q)
      begin
         if (exp_q.size() == 0)
            check("unexpected drive", 1'b0, 1'b1);
         else
            check("bus data", exp_q.pop_front(), dout);
      end
      for (int b = 0; b < 3; b++)
         if (zc[b] === 1'b1)
            zc_cnt[b]++;
   end
   task pulse(input int ch);
      @(posedge clk);
      #2 trg[ch] = 1'b1;
      repeat (4) @(posedge clk);
      #2 trg[ch] = 1'b0;
      repeat (6) @(posedge clk);
   endtask
   // bounded wait for a zero pulse, n = clocks waited
   task wait_zc(input int ch, output int n);
      n = 0;
      do
      begin
         @(negedge clk);
         n++;
         if (n > 2000)
         begin
            miscompares++;
            conclude;
         end
      end
      while (zc[ch] !== 1'b1);
   endtask
   // counter mode, k edges, count read after every edge
   task run_cnt(input int ch, input int k);
      int z;
      host.cyc(ch[1:0], 1'b0, 1'b0, 8'h47);
      host.cyc(ch[1:0], 1'b0, 1'b0, k[7:0]);
      z = zc_cnt[ch];
      for (int i = 1; i <= k; i++)
      begin
         pulse(ch);
         if (i >= k - 1)
            check("zero pulses", i / k, zc_cnt[ch] - z);
         exp_q.push_back(8'(i == k ? k : k - i));
         host.cyc(ch[1:0], 1'b1, 1'b0, 8'h00);
      end
      exp_q.push_back(k[7:0]);
      host.cyc(ch[1:0], 1'b1, 1'b0, 8'h00);
   endtask
   task tmr(input logic [7:0] cw, input logic [7:0] tc, input int p);
      int n;
      host.cyc(2'h1, 1'b0, 1'b0, cw);
      host.cyc(2'h1, 1'b0, 1'b0, tc);
      wait_zc(1, n);
      wait_zc(1, n);
      check("timer period", p, n);
   endtask
   initial
   begin
      int n;
      // a real rising edge so the async reset is seen at once
      #1 reset = 1'b1;
      repeat (16) @(posedge clk);
      #2 reset = 1'b0;
      repeat (2) @(posedge clk);
      run_cnt(0, 2 + ($unsigned($random(seed)) % 4));
      run_cnt(1, 256);
      run_cnt(2, 1);
      n = zc_cnt[2];
      host.cyc(2'h2, 1'b0, 1'b0, 8'h51);
      repeat (8) @(posedge clk);
      check("edge select", n + 1, zc_cnt[2]);
      tmr(8'h07, 8'h03, 48);
      tmr(8'h27, 8'h01, 256);
      host.cyc(2'h1, 1'b0, 1'b0, 8'h03);
      n = zc_cnt[1];
      repeat (600) @(posedge clk);
      check("stopped", n, zc_cnt[1]);
      host.cyc(2'h0, 1'b0, 1'b0, 8'ha8);
      host.cyc(2'h3, 1'b0, 1'b0, 8'hc7);
      host.cyc(2'h3, 1'b0, 1'b0, 8'h01);
      pulse(3);
      for (n = 0; n < 40 && irq_n !== 1'b0; n++)
         @(negedge clk);
      check("irq line", 1'b0, irq_n);
      check("chain pending", 1'b0, chain_out);
      exp_q.push_back(8'hae);
      host.cyc(2'h0, 1'b0, 1'b1, 8'h00);
      check("chain served", 1'b0, chain_out);
      host.fetch(8'hed);
      host.fetch(8'h4d);
      repeat (3) @(negedge clk);
      check("chain back", 1'b1, chain_out);
      @(posedge clk);
      #2 chain_in = 1'b0;
      repeat (2) @(negedge clk);
      check("chain in low", 1'b0, chain_out);
      @(posedge clk);
      #2 chain_in = 1'b1;
      reset = 1'b1;
      repeat (2) @(posedge clk);
      #2 reset = 1'b0;
      pulse(3);
      repeat (4) @(negedge clk);
      check("irq after reset", 1'b1, irq_n);
      conclude;
   end
endmodule
